// ### maf_pkg.sv
// Package for the monitor alarm and warning flag bank: offsets, layouts, reset values
`default_nettype none
package maf_pkg;
    localparam int MAF_CHANNELS = 5;
    localparam int MAF_VALUE_W = 16;

    // Channel indices
    localparam int MAF_CH_TEMP = 0;
    localparam int MAF_CH_SUPPLY = 1;
    localparam int MAF_CH_A = 2;
    localparam int MAF_CH_B = 3;
    localparam int MAF_CH_C = 4;

    // Register byte offsets on the device map
    localparam logic [7:0] MAF_ADDR_CONV_UPDATE = 8'h6F;
    localparam logic [7:0] MAF_ADDR_ALARM_PRI = 8'h70;
    localparam logic [7:0] MAF_ADDR_ALARM_SEC = 8'h71;
    localparam logic [7:0] MAF_ADDR_WARN_PRI = 8'h74;
    localparam logic [7:0] MAF_ADDR_WARN_SEC = 8'h75;

    // Field positions
    localparam int MAF_UPD_TEMP_BIT = 7;
    localparam int MAF_UPD_SUPPLY_BIT = 6;
    localparam int MAF_UPD_A_BIT = 5;
    localparam int MAF_UPD_B_BIT = 4;
    localparam int MAF_UPD_C_BIT = 3;
    localparam int MAF_SUMMARY_BIT = 0;

    // Reset values
    localparam logic MAF_FLAG_RST = 1'b0;
    localparam logic [7:0] MAF_BYTE_RST = 8'h00;
    localparam logic [7:0] MAF_UNMAPPED_DATA = 8'h00;

    typedef struct packed {
        logic [MAF_VALUE_W-1:0] alarm_high;
        logic [MAF_VALUE_W-1:0] alarm_low;
        logic [MAF_VALUE_W-1:0] warn_high;
        logic [MAF_VALUE_W-1:0] warn_low;
    } maf_limits_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } maf_reg_req_t;
endpackage
`default_nettype wire

// ### maf_flags.sv
// Alarm, warning and conversion-update flag bank of the five-channel monitor
`default_nettype none
module maf_flags
    import maf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // New measurements, one-cycle strobe per channel
    input wire logic [MAF_CHANNELS-1:0] meas_valid,
    input wire logic [MAF_CHANNELS-1:0][MAF_VALUE_W-1:0] meas_value,
    // Limits per channel
    input wire maf_pkg::maf_limits_t [MAF_CHANNELS-1:0] limits,
    // Interrupt mask byte
    input wire logic [7:0] int_mask,
    // Register access from the serial engine
    input wire maf_pkg::maf_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Summary indication
    output logic summary_interrupt_flag
);
    import maf_pkg::*;

    logic [MAF_CHANNELS-1:0] alarm_high_ff, alarm_low_ff, warn_high_ff, warn_low_ff;
    logic [MAF_CHANNELS-1:0] nxt_alarm_high, nxt_alarm_low, nxt_warn_high, nxt_warn_low;
    logic [MAF_CHANNELS-1:0] fresh_ff, nxt_fresh;
    logic [MAF_CHANNELS-1:0] fresh_clear;
    logic [7:0] update_byte, alarm_pri, alarm_sec, warn_pri, warn_sec;
    logic [7:0] masked_src;
    logic [7:0] rdata_ff, nxt_rdata;
    logic summary_ff, nxt_summary;
    logic upd_write;

    assign upd_write = reg_req.wr && (reg_req.addr == MAF_ADDR_CONV_UPDATE);

    // Update flag of each channel sits at a fixed bit; a written zero clears it
    assign fresh_clear[MAF_CH_TEMP] = upd_write && !reg_req.wdata[MAF_UPD_TEMP_BIT];
    assign fresh_clear[MAF_CH_SUPPLY] = upd_write && !reg_req.wdata[MAF_UPD_SUPPLY_BIT];
    assign fresh_clear[MAF_CH_A] = upd_write && !reg_req.wdata[MAF_UPD_A_BIT];
    assign fresh_clear[MAF_CH_B] = upd_write && !reg_req.wdata[MAF_UPD_B_BIT];
    assign fresh_clear[MAF_CH_C] = upd_write && !reg_req.wdata[MAF_UPD_C_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < MAF_CHANNELS; ch++) begin : g_chan
            always_comb begin
                nxt_alarm_high[ch] = alarm_high_ff[ch];
                nxt_alarm_low[ch] = alarm_low_ff[ch];
                nxt_warn_high[ch] = warn_high_ff[ch];
                nxt_warn_low[ch] = warn_low_ff[ch];
                // Flags follow the latest result only, so a recovered channel clears
                if (meas_valid[ch]) begin
                    nxt_alarm_high[ch] = meas_value[ch] > limits[ch].alarm_high;
                    nxt_alarm_low[ch] = meas_value[ch] < limits[ch].alarm_low;
                    nxt_warn_high[ch] = meas_value[ch] > limits[ch].warn_high;
                    nxt_warn_low[ch] = meas_value[ch] < limits[ch].warn_low;
                end
                // A fresh result beats a clear in the same cycle so no update is lost
                if (meas_valid[ch]) begin
                    nxt_fresh[ch] = 1'b1;
                end else if (fresh_clear[ch]) begin
                    nxt_fresh[ch] = 1'b0;
                end else begin
                    nxt_fresh[ch] = fresh_ff[ch];
                end
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    alarm_high_ff[ch] <= MAF_FLAG_RST;
                    alarm_low_ff[ch] <= MAF_FLAG_RST;
                    warn_high_ff[ch] <= MAF_FLAG_RST;
                    warn_low_ff[ch] <= MAF_FLAG_RST;
                    fresh_ff[ch] <= MAF_FLAG_RST;
                end else begin
                    alarm_high_ff[ch] <= nxt_alarm_high[ch];
                    alarm_low_ff[ch] <= nxt_alarm_low[ch];
                    warn_high_ff[ch] <= nxt_warn_high[ch];
                    warn_low_ff[ch] <= nxt_warn_low[ch];
                    fresh_ff[ch] <= nxt_fresh[ch];
                end
            end
        end
    endgenerate

    // Conversion-update image; bits 2..0 have no channel and read as zero
    always_comb begin
        update_byte = MAF_BYTE_RST;
        update_byte[MAF_UPD_TEMP_BIT] = fresh_ff[MAF_CH_TEMP];
        update_byte[MAF_UPD_SUPPLY_BIT] = fresh_ff[MAF_CH_SUPPLY];
        update_byte[MAF_UPD_A_BIT] = fresh_ff[MAF_CH_A];
        update_byte[MAF_UPD_B_BIT] = fresh_ff[MAF_CH_B];
        update_byte[MAF_UPD_C_BIT] = fresh_ff[MAF_CH_C];
    end

    // First alarm image: high flag above low flag for temp, supply, A and B
    always_comb begin
        alarm_pri = MAF_BYTE_RST;
        alarm_pri[7] = alarm_high_ff[MAF_CH_TEMP];
        alarm_pri[6] = alarm_low_ff[MAF_CH_TEMP];
        alarm_pri[5] = alarm_high_ff[MAF_CH_SUPPLY];
        alarm_pri[4] = alarm_low_ff[MAF_CH_SUPPLY];
        alarm_pri[3] = alarm_high_ff[MAF_CH_A];
        alarm_pri[2] = alarm_low_ff[MAF_CH_A];
        alarm_pri[1] = alarm_high_ff[MAF_CH_B];
        alarm_pri[0] = alarm_low_ff[MAF_CH_B];
    end

    // Second alarm image; the summary rides in bit 0, one cycle behind the flags
    always_comb begin
        alarm_sec = MAF_BYTE_RST;
        alarm_sec[7] = alarm_high_ff[MAF_CH_C];
        alarm_sec[6] = alarm_low_ff[MAF_CH_C];
        alarm_sec[MAF_SUMMARY_BIT] = summary_ff;
    end

    // First warning image, same layout as the first alarm image
    always_comb begin
        warn_pri = MAF_BYTE_RST;
        warn_pri[7] = warn_high_ff[MAF_CH_TEMP];
        warn_pri[6] = warn_low_ff[MAF_CH_TEMP];
        warn_pri[5] = warn_high_ff[MAF_CH_SUPPLY];
        warn_pri[4] = warn_low_ff[MAF_CH_SUPPLY];
        warn_pri[3] = warn_high_ff[MAF_CH_A];
        warn_pri[2] = warn_low_ff[MAF_CH_A];
        warn_pri[1] = warn_high_ff[MAF_CH_B];
        warn_pri[0] = warn_low_ff[MAF_CH_B];
    end

    // Second warning image; only input C lives here
    always_comb begin
        warn_sec = MAF_BYTE_RST;
        warn_sec[7] = warn_high_ff[MAF_CH_C];
        warn_sec[6] = warn_low_ff[MAF_CH_C];
    end

    // Mask bit n gates bit position n of each alarm and warning byte; the summary and the update byte are left out
    assign masked_src = int_mask & (alarm_pri | warn_pri |
                                    {alarm_sec[7:1], 1'b0} | warn_sec);

    always_comb begin
        nxt_summary = |masked_src;
        nxt_rdata = rdata_ff;
        if (reg_req.rd) begin
            case (reg_req.addr)
                MAF_ADDR_CONV_UPDATE: nxt_rdata = update_byte;
                MAF_ADDR_ALARM_PRI: nxt_rdata = alarm_pri;
                MAF_ADDR_ALARM_SEC: nxt_rdata = alarm_sec;
                MAF_ADDR_WARN_PRI: nxt_rdata = warn_pri;
                MAF_ADDR_WARN_SEC: nxt_rdata = warn_sec;
                default: nxt_rdata = MAF_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            summary_ff <= MAF_FLAG_RST;
            rdata_ff <= MAF_BYTE_RST;
        end else begin
            summary_ff <= nxt_summary;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign summary_interrupt_flag = summary_ff;
endmodule
`default_nettype wire

// ### maf_flags_monitor.sv
// Port-level assertions for the flag bank, bound to maf_flags
`default_nettype none
module maf_flags_monitor
    import maf_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [MAF_CHANNELS-1:0] meas_valid,
    input wire logic [MAF_CHANNELS-1:0][MAF_VALUE_W-1:0] meas_value,
    input wire maf_pkg::maf_limits_t [MAF_CHANNELS-1:0] limits,
    input wire logic [7:0] int_mask,
    input wire maf_pkg::maf_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic summary_interrupt_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_ah(c); meas_valid[c] && meas_value[c] > limits[c].alarm_high; endsequence
    sequence s_al(c); meas_valid[c] && meas_value[c] < limits[c].alarm_low; endsequence
    sequence s_wh(c); meas_valid[c] && meas_value[c] > limits[c].warn_high; endsequence
    sequence s_rd(a); reg_req.rd && reg_req.addr == a; endsequence
    // A read right after a measurement must already show that measurement
    property p_bit(s, a, b); s ##1 s_rd(a) |=> reg_rdata[b]; endproperty
    sequence s_clr;
        reg_req.wr && reg_req.addr == 8'h6F && reg_req.wdata == 8'h00 && meas_valid == 5'h00;
    endsequence
    AST_TEMP_HI: assert property (p_bit(s_ah(0), 8'h70, 7)) else $error("flag bit low");
    AST_SUP_LO: assert property (p_bit(s_al(1), 8'h70, 4)) else $error("flag bit low");
    AST_C_LO: assert property (p_bit(s_al(4), 8'h71, 6)) else $error("flag bit low");
    AST_WARN_C: assert property (p_bit(s_wh(4), 8'h75, 7)) else $error("flag bit low");
    AST_UPD_B: assert property (p_bit(meas_valid[3], 8'h6F, 4)) else $error("upd low");
    AST_CLEAR: assert property (s_clr ##1 s_rd(8'h6F) |=> reg_rdata[7:3] == 5'h00)
        else $error("update not cleared");
    AST_SUM_ON: assert property (s_ah(0) ##1 int_mask[7] |=> summary_interrupt_flag)
        else $error("summary low");
    AST_MASK_OFF: assert property (int_mask == 8'h00 |=> !summary_interrupt_flag)
        else $error("summary not masked");
endmodule
bind maf_flags maf_flags_monitor i_mon(.mclk(mclk), .resetn(resetn), .meas_valid(meas_valid),
    .meas_value(meas_value), .limits(limits), .int_mask(int_mask), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .summary_interrupt_flag(summary_interrupt_flag));
`default_nettype wire

// ### maf_host.sv
// Host model issuing byte register requests to the flag bank
`default_nettype none
module maf_host
    import maf_pkg::*;
(
    // Clock and read data
    input wire logic mclk,
    input wire logic [7:0] reg_rdata,
    // Request
    output maf_pkg::maf_reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // Caller releases with idle, so two requests may run back to back
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
        output logic [7:0] r);
        reg_req <= '{a, w, !w, d};
        @(negedge mclk);
        r = reg_rdata;
    endtask
    // Released fields flip so a stale address is never mistaken for a live one
    task automatic idle;
        reg_req <= '{~reg_req.addr, 1'b0, 1'b0, ~reg_req.wdata};
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ### maf_flags_tb.sv
// Random and corner-case bench for the flag bank
`default_nettype none
module maf_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import maf_pkg::*;
    logic mclk, resetn, summary_interrupt_flag, sum;
    logic [MAF_CHANNELS-1:0] meas_valid;
    logic [MAF_CHANNELS-1:0][MAF_VALUE_W-1:0] meas_value;
    maf_limits_t [MAF_CHANNELS-1:0] limits;
    logic [7:0] int_mask, reg_rdata, r, d, upd;
    maf_reg_req_t reg_req;
    logic [4:0] ah, al, wh, wl;
    int bad_count, checks, c, k;
    maf_flags i_dut(.mclk(mclk), .resetn(resetn), .meas_valid(meas_valid),
        .meas_value(meas_value), .limits(limits), .int_mask(int_mask), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .summary_interrupt_flag(summary_interrupt_flag));
    maf_host i_host(.mclk(mclk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        case (a)
            8'h6F: return upd & 8'hF8;
            8'h70: return {ah[0], al[0], ah[1], al[1], ah[2], al[2], ah[3], al[3]};
            8'h71: return {ah[4], al[4], 6'h00};
            8'h74: return {wh[0], wl[0], wh[1], wl[1], wh[2], wl[2], wh[3], wl[3]};
            8'h75: return {wh[4], wl[4], 6'h00};
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Optional measurement one cycle ahead of the register access
    task automatic op(input logic [4:0] v, input logic [7:0] a, input logic w);
        if (v != 5'h00) begin
            meas_valid <= v;
            @(negedge mclk);
            meas_valid <= '0;
            ah[c] = meas_value[c] > limits[c].alarm_high;
            al[c] = meas_value[c] < limits[c].alarm_low;
            wh[c] = meas_value[c] > limits[c].warn_high;
            wl[c] = meas_value[c] < limits[c].warn_low;
            upd[7-c] = 1'b1;
        end
        i_host.xfer(a, w, d, r);
        i_host.idle();
        if (w && a == 8'h6F) upd = upd & d;
        if (!w) begin
            case (a)
                8'h6F: chk("update", r, exp_byte(a));
                8'h70: chk("alarm0", r, exp_byte(a));
                8'h71: chk("alarm1", r & 8'hFE, exp_byte(a));
                8'h74: chk("warn0", r, exp_byte(a));
                8'h75: chk("warn1", r, exp_byte(a));
                default: chk("unmapped", r, exp_byte(a));
            endcase
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #2ms;
        bad_count++;
        end_of_test();
    end
    initial begin
        {resetn, meas_valid, meas_value, limits, int_mask, ah, al, wh, wl, upd, d} = '0;
        {bad_count, checks, c} = '0;
        void'($urandom(32'h949DE029));
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        for (int a = 8'h6F; a < 8'h77; a++) op(5'h00, 8'(a), 1'b0);
        for (int i = 0; i < 200; i++) begin
            c = $urandom % 5;
            k = $urandom % 4;
            int_mask = (i % 4 == 0) ? 8'h00 : 8'($urandom);
            limits[c] = {$urandom, $urandom};
            meas_value[c] = k == 0 ? limits[c].alarm_high + 16'h1 : k == 1 ?
                limits[c].alarm_low - 16'h1 : k == 2 ? limits[c].warn_high : 16'($urandom);
            for (int a = 8'h6F; a < 8'h77; a++) op(5'h01 << c, 8'(a), 1'b0);
            d = 8'($urandom);
            op(5'h00, i % 2 ? 8'h70 : 8'h6F, 1'b1);
            sum = |({exp_byte(8'h70), exp_byte(8'h71), exp_byte(8'h74), exp_byte(8'h75)}
                & {4{int_mask}});
            chk("summary", {7'h00, summary_interrupt_flag}, {7'h00, sum});
            if (i % 8 == 0) begin
                i_host.xfer(8'h6F, 1'b1, 8'h00, r);
                i_host.xfer(8'h6F, 1'b0, 8'h00, r);
                i_host.idle();
                chk("cleared", r, 8'h00);
                upd = 8'h00;
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
